/* core/aprr_pkg.sv */
// shared constants and types for the parallel result readout block
package aprr_pkg;
  localparam int RES_W = 14;
  localparam int BYTE_W = 8;
  localparam int HI_W = RES_W - BYTE_W;
  localparam int CLK_MHZ = 25;
  // longest time from hold to done, in nanoseconds
  localparam int CONV_MAX_NS = 4700;
  // conversion budget in cycles, rounded down
  localparam int CONV_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
  // cycles the internal converter is allowed to take per bit
  localparam int BIT_CYC = 8;
  localparam int CNT_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [CNT_W-1:0] BIT_CYC_LAST = CNT_W'(BIT_CYC - 1);
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(RES_W - 1);
  localparam logic [RES_W-1:0] RES_ZERO = 14'h0000;

  // control sequencer states, one-hot
  typedef enum logic [4:0] {
    APRR_IDLE = 5'h01,
    APRR_ACQ = 5'h02,
    APRR_CONV = 5'h04,
    APRR_DONE = 5'h08,
    APRR_READ = 5'h10
  } aprr_state_e;
endpackage

/* core/aprr_skid.sv */
// two-entry buffer between converter and result holding stage
`timescale 1ns/100ps
`default_nettype none
module aprr_skid
  import aprr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [RES_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [RES_W-1:0] out_data_o
);
  logic [RES_W-1:0] slot0;
  logic [RES_W-1:0] slot1;
  logic [1:0] count;
  logic [RES_W-1:0] next_slot0;
  logic [RES_W-1:0] next_slot1;
  logic [1:0] next_count;
  logic push;
  logic pop;

  // next entries; slot0 is always the head
  always_comb begin
    push = in_valid_i && (count != 2'h2);
    pop = out_ready_i && (count != 2'h0);
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_count = count;
    if (pop) begin
      next_slot0 = slot1;
    end
    if (push) begin
      if (count == 2'h0 || (count == 2'h1 && pop)) begin
        next_slot0 = in_data_i;
      end else begin
        next_slot1 = in_data_i;
      end
    end
    next_count = 2'(count + {1'b0, push} - {1'b0, pop});
  end

  // register entries
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot0 <= RES_ZERO;
      slot1 <= RES_ZERO;
      count <= 2'h0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      count <= next_count;
    end
  end

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = slot0;
endmodule
`default_nettype wire

/* core/aprr_top.sv */
// control sequencer and result bus drivers of the parallel converter
// How it works
// R01: done output falls when result is valid
// R02: fourteen three-state result bits, bit 0-13
// R03: bus floats during acquisition and conversion
// R04: third select fall, read high, drives result
// R05: select high floats the bus at once; the code floats it three clocks later, after the pin synchroniser
// R06: after read, idle until next select fall
// R07: wide variant whole word, narrow one byte
// R08: byte select low gives low byte
// R09: reset pin with select high restarts sequence
// R10: result coded as straight binary
// R11: host switches input channel after acquisition
// R12: first fall starts acquisition only read low
// R13: second fall holds sample, starts conversion
// R14: read line at second fall picks power mode
// R15: conversion finishes within the stated maximum
// R16: reset discards work, idles, floats bus
`timescale 1ns/100ps
`default_nettype none
module aprr_top
  import aprr_pkg::*;
#(
  parameter bit BYTE_WIDE = 1'b0
)(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic chip_sel_n_i,
  input wire logic read_conv_i,
  input wire logic high_byte_select_i,
  input wire logic dev_reset_i,
  input wire logic comp_i,
  output logic [RES_W-1:0] result_bus_o,
  output logic [RES_W-1:0] result_bus_oe_o,
  output logic conv_done_n_o,
  output logic track_o,
  output logic [RES_W-1:0] dac_trial_o,
  output logic shutdown_o
);
  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] rc_sync;
  logic [1:0] hb_sync;
  logic [1:0] rst_sync;
  logic [1:0] cmp_sync;
  logic cs_last;
  logic cs_fall;
  logic cs_rise_lvl;
  logic rc_s;
  logic hb_s;
  logic rst_s;
  logic cmp_s;

  // sequencer and converter state
  aprr_state_e state;
  aprr_state_e next_state;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] next_sar;
  logic [BIT_CNT_W-1:0] bit_idx;
  logic [BIT_CNT_W-1:0] next_bit_idx;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic shut_sel;
  logic next_shut_sel;
  logic conv_valid;
  logic conv_ready;
  logic buf_valid;
  logic buf_ready;
  logic [RES_W-1:0] buf_data;
  logic [RES_W-1:0] held;
  logic [RES_W-1:0] next_held;
  logic held_ok;
  logic next_held_ok;

  // output registers
  logic [RES_W-1:0] next_bus;
  logic [RES_W-1:0] next_oe;
  logic next_done_n;
  logic next_track;
  logic next_shutdown;
  logic [RES_W-1:0] next_trial;

  // two-stage capture of every pin
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_sync <= 2'h3;
      rc_sync <= 2'h0;
      hb_sync <= 2'h0;
      rst_sync <= 2'h0;
      cmp_sync <= 2'h0;
      cs_last <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], chip_sel_n_i};
      rc_sync <= {rc_sync[0], read_conv_i};
      hb_sync <= {hb_sync[0], high_byte_select_i};
      rst_sync <= {rst_sync[0], dev_reset_i};
      cmp_sync <= {cmp_sync[0], comp_i};
      cs_last <= cs_sync[1];
    end
  end

  // synchronised levels and select edge
  always_comb begin
    rc_s = rc_sync[1];
    hb_s = hb_sync[1];
    rst_s = rst_sync[1];
    cmp_s = cmp_sync[1];
    cs_rise_lvl = cs_sync[1];
    cs_fall = cs_last && !cs_sync[1];
  end

  // sequencer, bit-serial approximation and mode capture
  always_comb begin
    next_state = state;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_bit_cnt = bit_cnt;
    next_shut_sel = shut_sel;
    conv_valid = 1'b0;
    case (state)
      APRR_IDLE: begin
        if (cs_fall && !rc_s) begin // R12
          next_state = APRR_ACQ;
        end
      end
      APRR_ACQ: begin
        if (cs_fall) begin // R13
          next_state = APRR_CONV;
          next_shut_sel = rc_s; // R14
          next_sar = RES_ZERO;
          next_bit_idx = BIT_LAST;
          next_bit_cnt = '0;
        end
      end
      APRR_CONV: begin
        // one trial bit per BIT_CYC cycles, msb first; 14*8 cycles fits budget
        next_bit_cnt = CNT_W'(bit_cnt + 1'b1); // R15
        if (bit_cnt == BIT_CYC_LAST) begin
          next_bit_cnt = '0;
          next_sar[bit_idx] = cmp_s; // R10
          if (bit_idx == '0) begin
            conv_valid = 1'b1;
            if (conv_ready) begin
              next_state = APRR_DONE;
            end else begin
              next_sar[bit_idx] = sar[bit_idx];
              next_bit_cnt = bit_cnt;
            end
          end else begin
            next_bit_idx = BIT_CNT_W'(bit_idx - 1'b1);
          end
        end
      end
      APRR_DONE: begin
        if (cs_fall && rc_s) begin // R04
          next_state = APRR_READ;
        end
      end
      APRR_READ: begin
        if (cs_rise_lvl) begin // R06
          next_state = APRR_IDLE;
        end
      end
      default: begin
        next_state = APRR_IDLE;
      end
    endcase
    if (rst_s && cs_rise_lvl) begin // R09
      next_state = APRR_IDLE; // R16
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= APRR_IDLE;
      sar <= RES_ZERO;
      bit_idx <= '0;
      bit_cnt <= '0;
      shut_sel <= 1'b0;
    end else begin
      state <= next_state;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      bit_cnt <= next_bit_cnt;
      shut_sel <= next_shut_sel;
    end
  end

  // finished word passes through the two-entry buffer
  aprr_skid u_skid (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(conv_valid),
    .in_ready_o(conv_ready),
    .in_data_i(next_sar),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // holding stage takes a word only when the previous one is read or dropped
  always_comb begin
    buf_ready = !held_ok;
    next_held = held;
    next_held_ok = held_ok;
    if (buf_valid && buf_ready) begin
      next_held = buf_data;
      next_held_ok = 1'b1;
    end
    if ((state == APRR_READ && next_state == APRR_IDLE) || state == APRR_ACQ) begin
      next_held_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held <= RES_ZERO;
      held_ok <= 1'b0;
    end else begin
      held <= next_held;
      held_ok <= next_held_ok;
    end
  end

  // registered pin drivers
  always_comb begin
    next_bus = RES_ZERO;
    next_oe = RES_ZERO;
    next_done_n = 1'b1;
    next_track = (next_state == APRR_ACQ);
    next_shutdown = shut_sel && (next_state == APRR_DONE || next_state == APRR_READ);
    next_trial = next_sar;
    if (next_state == APRR_CONV) begin
      next_trial[next_bit_idx] = 1'b1;
    end
    if (next_state == APRR_DONE || next_state == APRR_READ) begin
      next_done_n = 1'b0; // R01
    end
    if (next_state == APRR_READ && !cs_rise_lvl) begin // R05
      if (BYTE_WIDE) begin // R07
        next_oe = {{HI_W{1'b0}}, {BYTE_W{1'b1}}};
        if (hb_s) begin // R08
          next_bus = {{HI_W{1'b0}}, {(2*BYTE_W-RES_W){1'b0}}, held[RES_W-1:BYTE_W]};
        end else begin
          next_bus = {{HI_W{1'b0}}, held[BYTE_W-1:0]};
        end
      end else begin
        next_oe = {RES_W{1'b1}}; // R02
        next_bus = held;
      end
    end
  end

  // the result bus floats outside a read, including acquisition and conversion
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_bus_o <= RES_ZERO;
      result_bus_oe_o <= RES_ZERO; // R03
      conv_done_n_o <= 1'b1;
      track_o <= 1'b0;
      dac_trial_o <= RES_ZERO;
      shutdown_o <= 1'b0;
    end else begin
      result_bus_o <= next_bus;
      result_bus_oe_o <= next_oe;
      conv_done_n_o <= next_done_n;
      track_o <= next_track;
      dac_trial_o <= next_trial;
      shutdown_o <= next_shutdown;
    end
  end
endmodule
`default_nettype wire

/* dv/aprr_ana_model.sv */
// analog core model: hold capacitor and comparator
`timescale 1ns/100ps
`default_nettype none
module aprr_ana_model
  import aprr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic track_i,
  input wire logic [RES_W-1:0] ain_i,
  input wire logic [RES_W-1:0] trial_i,
  output logic comp_o
);
  logic [RES_W-1:0] held;
  // sample follows input only while tracking
  always @(posedge sys_clk_i) if (track_i) held <= ain_i;
  // keep trial bit while sample not below it
  assign comp_o = (held >= trial_i);
endmodule
`default_nettype wire

/* dv/aprr_top_monitor.sv */
// port checker for the parallel result readout block
`timescale 1ns/100ps
`default_nettype none
module aprr_top_monitor
  import aprr_pkg::*;
#(
  parameter bit BYTE_WIDE = 1'b0
)(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic chip_sel_n_i,
  input wire logic read_conv_i,
  input wire logic high_byte_select_i,
  input wire logic dev_reset_i,
  input wire logic comp_i,
  input wire logic [RES_W-1:0] result_bus_o,
  input wire logic [RES_W-1:0] result_bus_oe_o,
  input wire logic conv_done_n_o,
  input wire logic track_o,
  input wire logic [RES_W-1:0] dac_trial_o,
  input wire logic shutdown_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus floats unless a result is waiting
  a_no_early_drive: assert property (conv_done_n_o |-> result_bus_oe_o == 0)
    else $error("bus driven without a result");
  a_done_window: assert property ($fell(track_o) |-> ##[1:117] $fell(conv_done_n_o))
    else $error("conversion overran its budget");
  a_release_float: assert property (chip_sel_n_i [*5] |-> result_bus_oe_o == 0)
    else $error("bus still driven after select high");
  a_read_drive: assert property (($fell(chip_sel_n_i) && read_conv_i && !conv_done_n_o)
    ##1 (!chip_sel_n_i && read_conv_i) [*5] |-> result_bus_oe_o[0])
    else $error("read did not drive the bus");
  a_byte_top: assert property ((BYTE_WIDE && high_byte_select_i) [*5] ##0 result_bus_oe_o[0]
    |-> result_bus_o[7:6] == 2'b00)
    else $error("upper byte carries stray bits");
  a_sd_after: assert property ($rose(shutdown_o) |-> !conv_done_n_o)
    else $error("shutdown before conversion end");
  a_sd_quiet: assert property (shutdown_o |-> !track_o)
    else $error("shutdown while tracking");
  a_reset_idle: assert property ((dev_reset_i && chip_sel_n_i) [*5]
    |-> conv_done_n_o && !track_o)
    else $error("device reset left work running");
  a_done_holds: assert property ((chip_sel_n_i && !dev_reset_i) [*6] ##0 !conv_done_n_o
    |=> !conv_done_n_o)
    else $error("done flag dropped while idle");
endmodule
bind aprr_top aprr_top_monitor #(.BYTE_WIDE(BYTE_WIDE)) u_mon (.sys_clk_i, .reset_n_i,
  .chip_sel_n_i, .read_conv_i, .high_byte_select_i, .dev_reset_i, .comp_i, .result_bus_o,
  .result_bus_oe_o, .conv_done_n_o, .track_o, .dac_trial_o, .shutdown_o);
`default_nettype wire

/* dv/aprr_top_tb.sv */
// self-checking bench for the parallel result readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module aprr_top_tb;
  import aprr_pkg::*;
  logic sys_clk_i = 0, reset_n_i = 0, cs_n = 1, rc = 0, hbs = 0, drst = 0, comp, m;
  logic [RES_W-1:0] bus, oe, trial, e, ain = 0;
  logic done_n, track, sd;
  logic [31:0] lf = 32'hE05B2273;
  logic [RES_W-1:0] q[$];
  int failures = 0, checked = 0, cyc = 0, t;
  always #20 sys_clk_i = ~sys_clk_i;
  aprr_top #(.BYTE_WIDE(1'b1)) u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_sel_n_i(cs_n), .read_conv_i(rc), .high_byte_select_i(hbs), .dev_reset_i(drst),
    .comp_i(comp), .result_bus_o(bus), .result_bus_oe_o(oe), .conv_done_n_o(done_n),
    .track_o(track), .dac_trial_o(trial), .shutdown_o(sd));
  aprr_ana_model u_ana (.sys_clk_i(sys_clk_i), .track_i(track), .ain_i(ain),
    .trial_i(trial), .comp_o(comp));
  // wide variant on the same pins, with its own analog core
  logic [RES_W-1:0] wbus, woe, wtrial;
  logic wcomp, wtrack;
  aprr_top #(.BYTE_WIDE(1'b0)) u_wide (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_sel_n_i(cs_n), .read_conv_i(rc), .high_byte_select_i(hbs), .dev_reset_i(drst),
    .comp_i(wcomp), .result_bus_o(wbus), .result_bus_oe_o(woe), .conv_done_n_o(),
    .track_o(wtrack), .dac_trial_o(wtrial), .shutdown_o());
  aprr_ana_model u_wana (.sys_clk_i(sys_clk_i), .track_i(wtrack), .ain_i(ain),
    .trial_i(wtrial), .comp_o(wcomp));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // one select pulse with the read line set
  task automatic fall(logic r);
    cs_n = 0;
    rc = r;
    step(5);
    cs_n = 1;
    step(5);
  endtask
  // bounded wait for the done flag
  task automatic wait_done();
    t = 0;
    while (done_n !== 1'b0 && t < 200) begin
      step(1);
      t++;
    end
  endtask
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    step(2);
    reset_n_i = 1;
    step(1);
    fall(1);
    `CHK("start ignored", 1'b0, track)
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      ain = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : lf[13:0];
      q.push_back(ain);
      m = lf[20];
      fall(0);
      `CHK("acq", 1'b1, track)
      `CHK("acq float", 14'h0000, oe)
      fall(m);
      ain = lf[27:14];
      `CHK("hold", 1'b0, track)
      `CHK("conv float", 14'h0000, oe)
      `CHK("wide conv float", 14'h0000, woe)
      wait_done();
      `CHK("conv time", 1'b1, (t + 10 <= CONV_CYC))
      step(2);
      `CHK("float", 14'h0000, oe)
      `CHK("mode", m, sd)
      e = q.pop_front();
      cs_n = 0;
      rc = 1;
      step(6);
      `CHK("oe", 8'hFF, oe[7:0])
      `CHK("low byte", e[7:0], bus[7:0])
      `CHK("narrow top oe", 6'h00, oe[13:8])
      `CHK("wide oe", 14'h3FFF, woe)
      `CHK("wide word", e, wbus)
      hbs = 1;
      step(5);
      `CHK("high byte", {2'b00, e[13:8]}, bus[7:0])
      `CHK("wide word hb", e, wbus)
      hbs = 0;
      cs_n = 1;
      step(5);
      `CHK("release", 14'h0000, oe)
      `CHK("wide release", 14'h0000, woe)
      `CHK("idle", 1'b1, done_n)
      $display("conversion %0d done", i);
    end
    // reset pin drops an unread result
    fall(0);
    fall(0);
    wait_done();
    drst = 1;
    step(6);
    drst = 0;
    step(4);
    `CHK("reset done", 1'b1, done_n)
    fall(1);
    `CHK("reset float", 14'h0000, oe)
    fall(0);
    `CHK("restart", 1'b1, track)
    $display("reset test done");
    complete_run();
  end
endmodule
`default_nettype wire
